// file: inc/drtf_consts.svh
// Purpose: Named offsets, field positions, codes and counts of the transfer flow block
// Assumes: Included by the design file
// Notes:   Byte offsets are AHB byte addresses within the block
`ifndef DRTF_CONSTS_SVH
`define DRTF_CONSTS_SVH

`define DRTF_ADDR_W        8
`define DRTF_GLB_BIT       7
`define DRTF_CH_MSB        6
`define DRTF_CH_LSB        5
`define DRTF_REG_MSB       4
`define DRTF_REG_LSB       2
// Word index inside one channel block
`define DRTF_CH_SRC        3'h0
`define DRTF_CH_DST        3'h1
`define DRTF_CH_CNT        3'h2
`define DRTF_CH_CTRL       3'h3
`define DRTF_CH_RELOAD     3'h4
// Word index inside the global block
`define DRTF_GLB_CTRL      3'h0
`define DRTF_GLB_SEL0      3'h1
`define DRTF_GLB_SEL1      3'h2
// Channel control bits
`define DRTF_CTRL_EN       0
`define DRTF_CTRL_TEND     1
`define DRTF_CTRL_IE       2
`define DRTF_CTRL_TS_LSB   3
`define DRTF_CTRL_TS_MSB   4
`define DRTF_CTRL_RPT      5
`define DRTF_CTRL_RSEL     6
`define DRTF_CTRL_RS_LSB   8
`define DRTF_CTRL_RS_MSB   11
`define DRTF_CTRL_DL       12
`define DRTF_CTRL_DS       13
`define DRTF_CTRL_DO       14
// Global control bits
`define DRTF_GLB_MEN       0
`define DRTF_GLB_NMI_ABORT_FLAG      1
`define DRTF_GLB_AEF       2
// Resource select codes
`define DRTF_RS_DUAL       4'h0
`define DRTF_RS_SNG_TODEV  4'h2
`define DRTF_RS_SNG_FRDEV  4'h3
`define DRTF_RS_AUTO       4'h4
`define DRTF_RS_MODULE     4'h8
// Module and register identifiers
`define DRTF_MID_ASYNC0    6'h08
`define DRTF_MID_ASYNC1    6'h0A
`define DRTF_MID_SYNC      6'h15
`define DRTF_MID_USB       6'h1C
`define DRTF_RID_TX        2'h1
`define DRTF_RID_RX        2'h2
`define DRTF_RID_USB0      2'h3
`define DRTF_RID_USB1      2'h0
// Transfer sizes
`define DRTF_TS_BYTE       2'h0
`define DRTF_TS_WORD       2'h1
`define DRTF_TS_LONG       2'h2
`define DRTF_TS_16B        2'h3
// Request line hold-off after acknowledge under overrun 0
`define DRTF_OVR0_HOLD     2'h3
// Request line hold-off after acknowledge under overrun 1
`define DRTF_OVR1_HOLD     2'h1
`define DRTF_RESET_WORD    32'h0000_0000

`endif

// file: inc/drtf_pkg.sv
// Purpose: Types shared by the transfer flow block and its bench
// Assumes: Constants come from drtf_consts.svh
// Notes:   One transfer unit leaves the block as one drtf_xfer_t
package drtf_pkg;

  typedef enum logic [1:0] {
    DRTF_ADDR_DUAL,
    DRTF_ADDR_SNG_TODEV,
    DRTF_ADDR_SNG_FRDEV
  } drtf_addr_mode_t;

  typedef struct packed {
    logic [1:0]      channel;
    logic [31:0]     src;
    logic [31:0]     dst;
    logic [1:0]      size;
    drtf_addr_mode_t mode;
  } drtf_xfer_t;

endpackage : drtf_pkg

// file: rtl/drtf_top.sv
// Purpose: Four-channel transfer request and transfer flow control, AHB-Lite registers
// Assumes: 25 MHz clk_i; periph_req_i from logic on clk_i; ext_req_i and nmi_i asynchronous
// Notes:   Fixed priority, channel 0 highest; one transfer unit per issued strobe
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "drtf_consts.svh"

module drtf_top #(
  parameter int CHANNELS = 4
) (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o,
  input  wire logic                ext_req_i,
  output logic                     ext_ack_o,
  input  wire logic [7:0]          periph_req_i,
  input  wire logic                nmi_i,
  output logic                     xfer_valid_o,
  output drtf_pkg::drtf_xfer_t     xfer_o,
  output logic [CHANNELS-1:0]      end_irq_o
);

  // Bus interface state
  logic                         wr_q;
  logic [`DRTF_ADDR_W-1:0]      wr_addr_q;
  logic                         wr_glb;
  logic [2:0]                   wr_reg;
  logic [31:0]                  next_rdata;
  // Global state
  logic                         master_en;
  logic                         nmi_flag;
  logic                         addr_err_flag;
  logic [15:0]                  sel0;
  logic [15:0]                  sel1;
  logic                         nmi_s1;
  logic                         nmi_s2;
  logic                         nmi_s3;
  logic                         ereq_s1;
  logic                         ereq_s2;
  logic                         ereq_s3;
  logic [1:0]                   ext_hold;
  // Per-channel state
  logic [31:0]                  src_q     [CHANNELS];
  logic [31:0]                  dst_q     [CHANNELS];
  logic [31:0]                  cnt_q     [CHANNELS];
  logic [31:0]                  cnt_init  [CHANNELS];
  logic [31:0]                  reload_q  [CHANNELS];
  logic [31:0]                  ctrl_rd   [CHANNELS];
  logic [1:0]                   ts_q      [CHANNELS];
  logic [3:0]                   rs_q      [CHANNELS];
  logic [CHANNELS-1:0]          run_ok;
  logic [CHANNELS-1:0]          pend;
  logic [CHANNELS-1:0]          tend;
  logic [CHANNELS-1:0]          ie;
  logic [CHANNELS-1:0]          dov;
  logic [CHANNELS-1:0]          misal;
  logic [CHANNELS-1:0]          gnt;
  logic [CHANNELS-1:0]          done;
  logic [1:0]                   gnt_ch;
  logic                         gnt_any;
  logic                         gnt_bad;

  function automatic logic [31:0] unit_step(input logic [1:0] ts);
    case (ts)
      `DRTF_TS_BYTE: unit_step = 32'h0000_0001;
      `DRTF_TS_WORD: unit_step = 32'h0000_0002;
      `DRTF_TS_LONG: unit_step = 32'h0000_0004;
      default:       unit_step = 32'h0000_0010;
    endcase
  endfunction : unit_step

  // Maps a selector byte to a module request line; bit 3 flags a valid code
  function automatic logic [3:0] module_line(input logic [7:0] sel);
    logic [5:0] mid;
    logic [1:0] register_identifier;
    mid = sel[7:2];
    register_identifier = sel[1:0];
    module_line = 4'h0;
    case (mid)
      `DRTF_MID_ASYNC0: module_line = (register_identifier == `DRTF_RID_TX) ? 4'h8 :
                                      (register_identifier == `DRTF_RID_RX) ? 4'h9 : 4'h0;
      `DRTF_MID_ASYNC1: module_line = (register_identifier == `DRTF_RID_TX) ? 4'hA :
                                      (register_identifier == `DRTF_RID_RX) ? 4'hB : 4'h0;
      `DRTF_MID_SYNC:   module_line = (register_identifier == `DRTF_RID_TX) ? 4'hC :
                                      (register_identifier == `DRTF_RID_RX) ? 4'hD : 4'h0;
      `DRTF_MID_USB:    module_line = (register_identifier == `DRTF_RID_USB0) ? 4'hE :
                                      (register_identifier == `DRTF_RID_USB1) ? 4'hF : 4'h0;
      default:          module_line = 4'h0;
    endcase
  endfunction : module_line

  // Bus: zero wait states, reads registered at the address phase edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q        <= 1'b0;
      wr_addr_q   <= '0;
      hrdata_o    <= `DRTF_RESET_WORD;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_q        <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
      wr_addr_q   <= haddr_i[`DRTF_ADDR_W-1:0];
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
    end
  end

  assign wr_glb = wr_q & wr_addr_q[`DRTF_GLB_BIT];
  assign wr_reg = wr_addr_q[`DRTF_REG_MSB:`DRTF_REG_LSB];

  always_comb begin
    next_rdata = `DRTF_RESET_WORD;
    if (haddr_i[`DRTF_GLB_BIT]) begin
      case (haddr_i[`DRTF_REG_MSB:`DRTF_REG_LSB])
        `DRTF_GLB_CTRL: begin
          next_rdata[`DRTF_GLB_MEN]  = master_en;
          next_rdata[`DRTF_GLB_NMI_ABORT_FLAG] = nmi_flag;
          next_rdata[`DRTF_GLB_AEF]  = addr_err_flag;
        end
        `DRTF_GLB_SEL0: next_rdata[15:0] = sel0;
        `DRTF_GLB_SEL1: next_rdata[15:0] = sel1;
        default:        next_rdata = `DRTF_RESET_WORD;
      endcase
    end else begin
      case (haddr_i[`DRTF_REG_MSB:`DRTF_REG_LSB])
        `DRTF_CH_SRC:    next_rdata = src_q[haddr_i[`DRTF_CH_MSB:`DRTF_CH_LSB]];
        `DRTF_CH_DST:    next_rdata = dst_q[haddr_i[`DRTF_CH_MSB:`DRTF_CH_LSB]];
        `DRTF_CH_CNT:    next_rdata = cnt_q[haddr_i[`DRTF_CH_MSB:`DRTF_CH_LSB]];
        `DRTF_CH_CTRL:   next_rdata = ctrl_rd[haddr_i[`DRTF_CH_MSB:`DRTF_CH_LSB]];
        `DRTF_CH_RELOAD: next_rdata = reload_q[haddr_i[`DRTF_CH_MSB:`DRTF_CH_LSB]];
        default:         next_rdata = `DRTF_RESET_WORD;
      endcase
    end
  end

  // Asynchronous pins: two flops, third flop only for edge compare
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_s1  <= 1'b0;
      nmi_s2  <= 1'b0;
      nmi_s3  <= 1'b0;
      ereq_s1 <= 1'b0;
      ereq_s2 <= 1'b0;
      ereq_s3 <= 1'b0;
    end else begin
      nmi_s1  <= nmi_i;
      nmi_s2  <= nmi_s1;
      nmi_s3  <= nmi_s2;
      ereq_s1 <= ext_req_i;
      ereq_s2 <= ereq_s1;
      ereq_s3 <= ereq_s2;
    end
  end

  // Global control and flags; a hardware set wins over a software clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      master_en     <= 1'b0;
      nmi_flag      <= 1'b0;
      addr_err_flag <= 1'b0;
      sel0          <= '0;
      sel1          <= '0;
    end else begin
      if (wr_glb && wr_reg == `DRTF_GLB_CTRL) begin
        master_en     <= hwdata_i[`DRTF_GLB_MEN];
        nmi_flag      <= nmi_flag & hwdata_i[`DRTF_GLB_NMI_ABORT_FLAG];
        addr_err_flag <= addr_err_flag & hwdata_i[`DRTF_GLB_AEF];
      end
      if (nmi_s2 && !nmi_s3) begin
        nmi_flag <= 1'b1;
      end
      if (gnt_bad) begin
        addr_err_flag <= 1'b1;
      end
      if (wr_glb && wr_reg == `DRTF_GLB_SEL0) begin
        sel0 <= hwdata_i[15:0];
      end
      if (wr_glb && wr_reg == `DRTF_GLB_SEL1) begin
        sel1 <= hwdata_i[15:0];
      end
    end
  end

  // Fixed priority pick among channels holding an accepted request
  always_comb begin
    gnt    = '0;
    gnt_ch = 2'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pend[i] && run_ok[i]) begin
        gnt    = '0;
        gnt[i] = 1'b1;
        gnt_ch = 2'(i);
      end
    end
  end

  assign gnt_any = |gnt;
  assign gnt_bad = |(gnt & misal);
  assign done    = gnt & ~misal;

  // Transfer strobe and acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xfer_valid_o <= 1'b0;
      xfer_o       <= '0;
      ext_ack_o    <= 1'b0;
    end else begin
      xfer_valid_o <= gnt_any & ~gnt_bad;
      ext_ack_o    <= done[0] & (rs_q[0] == `DRTF_RS_DUAL ||
                                 rs_q[0] == `DRTF_RS_SNG_TODEV ||
                                 rs_q[0] == `DRTF_RS_SNG_FRDEV);
      if (gnt_any) begin
        xfer_o.channel <= gnt_ch;
        xfer_o.src     <= src_q[gnt_ch];
        xfer_o.dst     <= dst_q[gnt_ch];
        xfer_o.size    <= ts_q[gnt_ch];
        case (rs_q[gnt_ch])
          `DRTF_RS_SNG_TODEV: xfer_o.mode <= drtf_pkg::DRTF_ADDR_SNG_TODEV;
          `DRTF_RS_SNG_FRDEV: xfer_o.mode <= drtf_pkg::DRTF_ADDR_SNG_FRDEV;
          default:            xfer_o.mode <= drtf_pkg::DRTF_ADDR_DUAL;
        endcase
      end
    end
  end

  // Under overrun 0 the pin is held off until the requester's release has crossed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_hold <= 2'h0;
    end else if (done[0]) begin
      // Overrun 1 skips only the acknowledge cycle, so a still-held level gives one extra unit
      ext_hold <= dov[0] ? `DRTF_OVR1_HOLD : `DRTF_OVR0_HOLD;
    end else if (ext_hold != 2'h0) begin
      ext_hold <= ext_hold - 2'h1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic       wr_ch;
      logic       en;
      logic       repeat_enable;
      logic       rsel;
      logic       dl;
      logic       ds;
      logic [7:0] sel_byte;
      logic [3:0] line;
      logic       ext_mode;
      logic       ext_hit;
      logic       trig;
      logic [31:0] step;
      logic [31:0] amask;

      assign wr_ch = wr_q & ~wr_addr_q[`DRTF_GLB_BIT] &
                     (wr_addr_q[`DRTF_CH_MSB:`DRTF_CH_LSB] == 2'(ch));
      assign sel_byte = (ch < 2) ? sel0[(ch % 2) * 8 +: 8] : sel1[(ch % 2) * 8 +: 8];
      assign line     = module_line(sel_byte);
      assign step     = unit_step(ts_q[ch]);
      assign amask    = step - 32'h0000_0001;
      assign misal[ch] = |((src_q[ch] | dst_q[ch]) & amask);

      assign run_ok[ch] = en & master_en & ~tend[ch] & ~addr_err_flag & ~nmi_flag &
                          (cnt_q[ch] != 32'h0);

      assign ext_mode = (ch == 0) && (rs_q[ch] == `DRTF_RS_DUAL ||
                        rs_q[ch] == `DRTF_RS_SNG_TODEV ||
                        rs_q[ch] == `DRTF_RS_SNG_FRDEV);

      always_comb begin
        case ({dl, ds})
          2'b00:   ext_hit = ~ereq_s2;
          2'b01:   ext_hit = ereq_s3 & ~ereq_s2;
          2'b10:   ext_hit = ereq_s2;
          default: ext_hit = ereq_s2 & ~ereq_s3;
        endcase
      end

      always_comb begin
        case (rs_q[ch])
          `DRTF_RS_AUTO:   trig = 1'b1;
          `DRTF_RS_MODULE: trig = line[3] & periph_req_i[line[2:0]];
          default:         trig = ext_mode & ext_hit & (ext_hold == 2'h0);
        endcase
      end

      // An accepted request stays pending, masking the pin, until its unit is issued or the channel stops running
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pend[ch] <= 1'b0;
        end else if (!run_ok[ch]) begin
          pend[ch] <= 1'b0;
        end else if (done[ch]) begin
          pend[ch] <= 1'b0;
        end else if (!pend[ch] && trig) begin
          pend[ch] <= 1'b1;
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          en       <= 1'b0;
          ie[ch]   <= 1'b0;
          ts_q[ch] <= `DRTF_TS_BYTE;
          repeat_enable      <= 1'b0;
          rsel     <= 1'b0;
          rs_q[ch] <= `DRTF_RS_DUAL;
          dl       <= 1'b0;
          ds       <= 1'b0;
          dov[ch]  <= 1'b0;
        end else if (wr_ch && wr_reg == `DRTF_CH_CTRL) begin
          en       <= hwdata_i[`DRTF_CTRL_EN];
          ie[ch]   <= hwdata_i[`DRTF_CTRL_IE];
          ts_q[ch] <= hwdata_i[`DRTF_CTRL_TS_MSB:`DRTF_CTRL_TS_LSB];
          repeat_enable      <= hwdata_i[`DRTF_CTRL_RPT];
          rsel     <= hwdata_i[`DRTF_CTRL_RSEL];
          rs_q[ch] <= hwdata_i[`DRTF_CTRL_RS_MSB:`DRTF_CTRL_RS_LSB];
          dl       <= hwdata_i[`DRTF_CTRL_DL];
          ds       <= hwdata_i[`DRTF_CTRL_DS];
          dov[ch]  <= hwdata_i[`DRTF_CTRL_DO];
        end
      end

      // End flag: writing 0 clears, completion in the same cycle wins
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          tend[ch] <= 1'b0;
        end else if (done[ch] && cnt_q[ch] == 32'h1) begin
          tend[ch] <= 1'b1;
        end else if (wr_ch && wr_reg == `DRTF_CH_CTRL) begin
          tend[ch] <= tend[ch] & hwdata_i[`DRTF_CTRL_TEND];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          end_irq_o[ch] <= 1'b0;
        end else begin
          end_irq_o[ch] <= tend[ch] & ie[ch];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          reload_q[ch] <= `DRTF_RESET_WORD;
        end else if (wr_ch && wr_reg == `DRTF_CH_RELOAD) begin
          reload_q[ch] <= hwdata_i;
        end
      end

      // Software writes are meant for a stopped channel and take priority
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          src_q[ch] <= `DRTF_RESET_WORD;
          dst_q[ch] <= `DRTF_RESET_WORD;
        end else begin
          if (wr_ch && wr_reg == `DRTF_CH_SRC) begin
            src_q[ch] <= hwdata_i;
          end else if (done[ch] && cnt_q[ch] == 32'h1 && repeat_enable && !rsel) begin
            src_q[ch] <= reload_q[ch];
          end else if (done[ch]) begin
            src_q[ch] <= src_q[ch] + step;
          end
          if (wr_ch && wr_reg == `DRTF_CH_DST) begin
            dst_q[ch] <= hwdata_i;
          end else if (done[ch] && cnt_q[ch] == 32'h1 && repeat_enable && rsel) begin
            dst_q[ch] <= reload_q[ch];
          end else if (done[ch]) begin
            dst_q[ch] <= dst_q[ch] + step;
          end
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cnt_q[ch]    <= `DRTF_RESET_WORD;
          cnt_init[ch] <= `DRTF_RESET_WORD;
        end else if (wr_ch && wr_reg == `DRTF_CH_CNT) begin
          cnt_q[ch]    <= hwdata_i;
          cnt_init[ch] <= hwdata_i;
        end else if (done[ch] && cnt_q[ch] == 32'h1 && repeat_enable) begin
          cnt_q[ch] <= cnt_init[ch];
        end else if (done[ch]) begin
          cnt_q[ch] <= cnt_q[ch] - 32'h1;
        end
      end

      always_comb begin
        ctrl_rd[ch]                                        = `DRTF_RESET_WORD;
        ctrl_rd[ch][`DRTF_CTRL_EN]                         = en;
        ctrl_rd[ch][`DRTF_CTRL_TEND]                       = tend[ch];
        ctrl_rd[ch][`DRTF_CTRL_IE]                         = ie[ch];
        ctrl_rd[ch][`DRTF_CTRL_TS_MSB:`DRTF_CTRL_TS_LSB]   = ts_q[ch];
        ctrl_rd[ch][`DRTF_CTRL_RPT]                        = repeat_enable;
        ctrl_rd[ch][`DRTF_CTRL_RSEL]                       = rsel;
        ctrl_rd[ch][`DRTF_CTRL_RS_MSB:`DRTF_CTRL_RS_LSB]   = rs_q[ch];
        ctrl_rd[ch][`DRTF_CTRL_DL]                         = dl;
        ctrl_rd[ch][`DRTF_CTRL_DS]                         = ds;
        ctrl_rd[ch][`DRTF_CTRL_DO]                         = dov[ch];
      end
    end
  endgenerate

endmodule : drtf_top

// file: bench/drtf_top_asserts.sv
// Purpose: Port checks for drtf_top
// Assumes: Bound to every drtf_top instance
// Notes:   Ties the bus status, acknowledge and strobe outputs to their causes; hrdata_o and end_irq_o are not checked
`timescale 1ns/1ps
module drtf_top_asserts #(
  parameter int CHANNELS = 4
) (
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 hreadyout_o,
  input wire logic                 hresp_o,
  input wire logic                 ext_ack_o,
  input wire logic                 nmi_i,
  input wire logic                 xfer_valid_o,
  input wire drtf_pkg::drtf_xfer_t xfer_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [3:0] mask;
  assign mask = {{2{xfer_o.size == 2'h3}}, xfer_o.size[1], |xfer_o.size};
  // Two sync flops and the flag leave a few strobes in flight
  sequence s_nmi_seen;
    $rose(nmi_i) ##5 1'b1;
  endsequence
  chk_ack_with_unit: assert property (
    ext_ack_o |-> xfer_valid_o && xfer_o.channel == 2'h0)
    else $error("acknowledge without a channel 0 unit");
  chk_unit_spacing: assert property (
    xfer_valid_o |=> !(xfer_valid_o && xfer_o.channel == $past(xfer_o.channel)))
    else $error("two units of one channel back to back");
  chk_nmi_quiet: assert property (s_nmi_seen |-> (!xfer_valid_o) [*8])
    else $error("unit moved after nmi");
  chk_resp_okay: assert property (!hresp_o)
    else $error("bus response not okay");
  chk_ready_high: assert property ($past(reset_n_i) |-> hreadyout_o)
    else $error("bus ready low");
  chk_addr_aligned: assert property (
    xfer_valid_o |-> ((xfer_o.src[3:0] | xfer_o.dst[3:0]) & mask) == 4'h0)
    else $error("unit issued on misaligned address");
  chk_far_chan_dual: assert property (
    xfer_valid_o && xfer_o.channel != 2'h0 |-> xfer_o.mode == drtf_pkg::DRTF_ADDR_DUAL)
    else $error("single address mode off channel 0");
  chk_single_acked: assert property (
    xfer_valid_o && xfer_o.mode != drtf_pkg::DRTF_ADDR_DUAL |-> ext_ack_o)
    else $error("single address unit without acknowledge");
endmodule : drtf_top_asserts

bind drtf_top drtf_top_asserts #(.CHANNELS(CHANNELS)) u_drtf_top_asserts (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .ext_ack_o(ext_ack_o), .nmi_i(nmi_i), .xfer_valid_o(xfer_valid_o), .xfer_o(xfer_o));

// file: bench/drtf_ext_dev.sv
// Purpose: External requester on the request/acknowledge pin pair
// Assumes: active_i gives the asserted pin level
// Notes:   Drops the request at the acknowledge edge
`timescale 1ns/1ps
module drtf_ext_dev (
  input  wire logic clk_i,
  input  wire logic active_i,
  input  wire logic ack_i,
  output logic      req_o
);
  logic on = 1'b0;
  assign req_o = on ? active_i : !active_i;
  task automatic request(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      on <= 1'b1;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      on <= 1'b0;
      // Gap beyond the hold-off so no edge is lost
      repeat (6) @(posedge clk_i);
    end
  endtask : request
endmodule : drtf_ext_dev

// file: bench/test_drtf_top.sv
// Purpose: Self-checking bench of drtf_top
// Assumes: One AHB slave, hready fed back from hreadyout
// Notes:   Unit counts per channel come from the strobe monitor
`timescale 1ns/1ps
module test_drtf_top;
  logic                 clk_i = 1'b0, rn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0]           htrans = 2'h0;
  logic [7:0]           preq = 8'h00, sel [8];
  logic                 nmi = 1'b0, act = 1'b0, ext_req, ext_ack, xv;
  logic [3:0]           irq;
  drtf_pkg::drtf_xfer_t xf;
  int                   n_mismatch = 0, n_compared = 0, units [4], b, m, i;
  logic [31:0]          lsrc [4], ldst [4];
  always #20 clk_i = ~clk_i;
  drtf_top u_drtf_top (.clk_i(clk_i), .reset_n_i(rn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata), .ext_req_i(ext_req),
    .ext_ack_o(ext_ack), .periph_req_i(preq), .nmi_i(nmi), .xfer_valid_o(xv), .xfer_o(xf),
    .end_irq_o(irq));
  drtf_ext_dev u_drtf_ext_dev (.clk_i(clk_i), .active_i(act), .ack_i(ext_ack), .req_o(ext_req));
  always @(posedge clk_i) if (xv) begin
    units[xf.channel] <= units[xf.channel] + 1;
    lsrc[xf.channel] <= xf.src;
    ldst[xf.channel] <= xf.dst;
  end
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    d = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    ahb(a, 1'b1, wd);
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(d, exp);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    sel = '{8'h21, 8'h22, 8'h29, 8'h2A, 8'h55, 8'h56, 8'h73, 8'h70};
    tick(20);
    rn <= 1'b1;
    tick(1);
    rc(8'h8C, 32'h0);
    wr(8'h20, 32'h100);
    wr(8'h24, 32'h200);
    wr(8'h28, 32'h3);
    rc(8'h20, 32'h100);
    wr(8'h2C, 32'h0415);
    tick(10);
    chk(units[1], 0);
    wr(8'h80, 32'h1);
    tick(30);
    chk(units[1], 3);
    chk(lsrc[1], 32'h108);
    chk(irq[1], 1'b1);
    rc(8'h28, 32'h0);
    rc(8'h2C, 32'h0417);
    wr(8'h40, 32'h300);
    wr(8'h44, 32'h500);
    wr(8'h48, 32'h2);
    wr(8'h50, 32'h400);
    wr(8'h4C, 32'h0461);
    tick(20);
    chk(units[2], 2);
    chk(ldst[2], 32'h501);
    chk(irq[2], 1'b0);
    rc(8'h44, 32'h400);
    rc(8'h48, 32'h2);
    chk(units[2], 2);
    wr(8'h4C, 32'h0461);
    tick(20);
    chk(units[2], 4);
    chk(ldst[2], 32'h401);
    wr(8'h28, 32'h4);
    wr(8'h2C, 32'h0001);
    wr(8'h00, 32'h600);
    wr(8'h04, 32'h900);
    for (m = 0; m < 5; m++) begin
      wr(8'h0C, 32'h0);
      act <= m[0] & (m < 4);
      wr(8'h08, 32'h8);
      wr(8'h0C, (m < 4) ? {18'h0, m[1:0], 12'h201} : 32'h4201);
      b = units[0];
      u_drtf_ext_dev.request((m < 4) ? 2 : 1);
      tick(10);
      chk(units[0] - b, 2);
    end
    chk(units[1], 3);
    wr(8'h60, 32'h700);
    wr(8'h64, 32'h800);
    wr(8'h68, 32'h10);
    wr(8'h6C, 32'h0801);
    for (i = 0; i < 8; i++) begin
      wr(8'h88, {16'h0, sel[i], 8'h00});
      b = units[3];
      preq <= ~(8'h01 << i);
      tick(1);
      preq <= 8'h00;
      tick(8);
      chk(units[3], b);
      preq <= 8'h01 << i;
      tick(1);
      preq <= 8'h00;
      tick(8);
      chk(units[3], b + 1);
    end
    wr(8'h6C, 32'h0001);
    preq <= 8'h80;
    tick(1);
    preq <= 8'h00;
    tick(8);
    chk(units[3], b + 1);
    wr(8'h28, 32'h28);
    wr(8'h2C, 32'h0401);
    tick(6);
    nmi <= 1'b1;
    tick(1);
    nmi <= 1'b0;
    tick(20);
    b = units[1];
    tick(20);
    chk(units[1], b);
    rc(8'h80, 32'h3);
    wr(8'h80, 32'h1);
    tick(10);
    chk(units[1] > b, 1'b1);
    wr(8'h80, 32'h0);
    tick(4);
    b = units[1];
    tick(20);
    chk(units[1], b);
    give_verdict();
  end
endmodule : test_drtf_top
